/* rtl/clock_ctrl_pkg.sv */
// shared register map, field layout, reset values and timing of the clock control block
package clock_ctrl_pkg;

  localparam int CLK_SYS_MHZ = 50;

  // register byte addresses
  localparam logic [7:0] ADDR_CLOCK_MODE     = 8'h00;
  localparam logic [7:0] ADDR_CLOCK_MODE_EXT = 8'h04;
  localparam logic [7:0] ADDR_OSC_STOP_DET   = 8'h08;
  localparam logic [7:0] ADDR_FAST_OSC_CTRL  = 8'h0C;
  localparam logic [7:0] ADDR_FAST_OSC_TRIM  = 8'h10;
  localparam logic [7:0] ADDR_FAST_OSC_DIV   = 8'h14;
  localparam logic [7:0] ADDR_VOLTAGE_DET    = 8'h18;
  localparam logic [7:0] ADDR_WRITE_PROTECT  = 8'h1C;
  localparam logic [7:0] ADDR_STATUS         = 8'h20;

  // field positions
  localparam int CLOCK_SOURCE_PIN_SELECT_BIT = 1;
  localparam int SUB_DRIVE_CAPACITY_BIT      = 3;
  localparam int SUB_CLOCK_OSCILLATE_BIT     = 4;
  localparam int MAIN_CLOCK_STOP_BIT         = 5;
  localparam int CPU_DIV8_SELECT_BIT         = 6;
  localparam int STOP_MODE_BIT_POS           = 0;
  localparam int MAIN_PIN_SELECT_BIT         = 3;
  localparam int SLOW_OSC_STOP_BIT           = 4;
  localparam int MAIN_DRIVE_CAPACITY_BIT     = 5;
  localparam int CPU_DIVIDER_LOW_BIT         = 6;
  localparam int CPU_DIVIDER_HIGH_BIT        = 7;
  localparam int STOP_DETECT_ENABLE_BIT      = 0;
  localparam int STOP_DETECT_INT_ENABLE_BIT  = 1;
  localparam int ONCHIP_CLOCK_SELECT_BIT     = 2;
  localparam int MAIN_CLOCK_STOPPED_BIT      = 3;
  localparam int FAST_OSC_ON_BIT             = 0;
  localparam int ONCHIP_OSC_SELECT_BIT       = 1;
  localparam int MONITOR0_ENABLE_BIT         = 5;
  localparam int CLOCK_REG_WRITE_ENABLE_BIT  = 0;
  localparam int VOLTAGE_REG_WRITE_ENABLE_BIT = 3;
  localparam int MONITORS                    = 3;

  // reset values
  localparam logic [7:0] CLOCK_MODE_RESET     = 8'h68;
  localparam logic [7:0] CLOCK_MODE_EXT_RESET = 8'h20;
  localparam logic [7:0] OSC_STOP_DET_RESET   = 8'h04;
  localparam logic [7:0] FAST_OSC_CTRL_RESET  = 8'h00;
  localparam logic [7:0] FAST_OSC_TRIM_RESET  = 8'h80;
  localparam logic [7:0] FAST_OSC_DIV_RESET   = 8'h00;
  localparam logic [7:0] VOLTAGE_DET_RESET    = 8'h00;
  localparam logic [7:0] WRITE_PROTECT_RESET  = 8'h00;

  // cpu divider shift values and fast oscillator limit
  localparam logic [2:0] DIV8_SHIFT            = 3'h3;
  localparam logic [2:0] DIV16_SHIFT           = 3'h4;
  localparam int         FAST_OSC_MHZ          = 40;
  localparam int         CPU_MAX_MHZ           = 20;
  localparam int         FAST_OSC_PREDIVIDE    = (FAST_OSC_MHZ + CPU_MAX_MHZ - 1) / CPU_MAX_MHZ;

  // timing
  localparam int LOSS_SLOW_EDGES          = 4;
  localparam int DETECTOR_ENABLE_DELAY_US = 100;
  localparam int DETECTOR_ENABLE_CYCLES   = DETECTOR_ENABLE_DELAY_US * CLK_SYS_MHZ;

  typedef struct packed {
    logic       main_feedback_en;
    logic       main_buffer_en;
    logic       main_input_en;
    logic       sub_feedback_en;
    logic       port_pins_free;
    logic       fast_prediv_en;
    logic       slow_osc_run;
    logic       fast_osc_run;
    logic [2:0] cpu_div_shift;
  } clock_ctrl_t;

  typedef struct packed {
    logic main_o;
    logic main_oe;
    logic sub_o;
    logic sub_oe;
  } osc_pins_t;

endpackage

/* rtl/enable_delay_timer.sv */
// per monitor wait from enable to active
`timescale 1ns/10ps
module enable_delay_timer
  import clock_ctrl_pkg::*;
#(
  parameter int COUNT = DETECTOR_ENABLE_CYCLES
)
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic enable,
  output logic      active
);

  localparam int W = $clog2(COUNT + 1);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic         active_next;

  always_comb
  begin
    count_next  = count_reg;
    active_next = active;
    if (!enable)
    begin
      count_next  = '0;
      active_next = 1'b0;
    end
    else if (count_reg == W'(COUNT - 1))
      active_next = 1'b1;
    else
      count_next = count_reg + W'(1);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      count_reg <= '0;
      active    <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      active    <= active_next;
    end
  end

endmodule

/* rtl/clock_source_control_regs.sv */
// clock source control and status registers behind an apb slave
//
// Overview of operation
// - mode, stop detect and trim registers writable only with write enable; fast control and divider always writable
// - sub oscillate bit sets, never clears
// - main pin select sticky once set
// - stop entry sets div8 and drive bits
// - stop mode disconnects main feedback resistor
// - stop mode sub output high or input
// - stop mode main output high or input
// - slow stop bit follows on-chip select
// - protect mode ignores stop and slow writes
// - divider bits used only without div8
// - pins free when both oscillators unused
// - external clock: only buffer turned off
// - detected loss forces on-chip clock select when stop detect and its interrupt are both enabled
// - stopped flag blocks clearing on-chip select
// - stopped flag zero when detection off
// - fast oscillator predivided to 20 mhz
// - monitor starts after enable delay
// - voltage register survives soft resets
// - cpu clock divides by 1 to 16
// - reset gives slow oscillator divided by 8
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module clock_source_control_regs
  import clock_ctrl_pkg::*;
#(
  parameter int ENABLE_DELAY_CYCLES = DETECTOR_ENABLE_CYCLES
)
(
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             soft_reset,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             wdt_protect_mode,
  input  wire logic             stop_wake,
  input  wire logic             main_osc_input,
  input  wire logic             slow_osc_clk,
  output clock_ctrl_t           clock_ctrl,
  output osc_pins_t             osc_pins,
  output logic [MONITORS-1:0]   monitor_active
);

  logic [7:0] clock_mode_reg;
  logic [7:0] clock_mode_next;
  logic [7:0] clock_mode_ext_reg;
  logic [7:0] clock_mode_ext_next;
  logic [7:0] osc_stop_detect_reg;
  logic [7:0] osc_stop_detect_next;
  logic [7:0] fast_osc_ctrl_reg;
  logic [7:0] fast_osc_ctrl_next;
  logic [7:0] fast_osc_trim_reg;
  logic [7:0] fast_osc_trim_next;
  logic [7:0] fast_osc_divider_reg;
  logic [7:0] fast_osc_divider_next;
  logic [7:0] voltage_detect_ctrl_reg;
  logic [7:0] voltage_detect_ctrl_next;
  logic [7:0] write_protect_reg;
  logic [7:0] write_protect_next;
  logic [31:0] prdata_next;

  logic [2:0] main_sync_reg;
  logic [2:0] slow_sync_reg;
  logic [2:0] loss_count_reg;
  logic [2:0] loss_count_next;
  logic       lost_reg;
  logic       lost_next;

  logic       wr;
  logic       rd_setup;
  logic       mapped;
  logic       clock_we;
  logic       volt_we;
  logic       stop_mode;
  logic       onchip_sel;
  logic       detect_on;
  logic       stopped_flag;
  logic       main_edge;
  logic       slow_edge;
  logic [7:0] wd;
  logic [7:0] status;

  assign wd        = pwdata[7:0];
  assign wr        = psel && penable && pwrite;
  assign rd_setup  = psel && !penable && !pwrite;
  assign clock_we  = write_protect_reg[CLOCK_REG_WRITE_ENABLE_BIT];
  assign volt_we   = write_protect_reg[VOLTAGE_REG_WRITE_ENABLE_BIT];
  assign stop_mode = clock_mode_ext_reg[STOP_MODE_BIT_POS];
  assign onchip_sel = osc_stop_detect_reg[ONCHIP_CLOCK_SELECT_BIT];
  assign detect_on = osc_stop_detect_reg[STOP_DETECT_ENABLE_BIT];

  // flag only means something with detection on; reads zero when both bits are 00
  assign stopped_flag = lost_reg && detect_on;

  always_comb
  begin
    case (paddr)
      ADDR_CLOCK_MODE, ADDR_CLOCK_MODE_EXT, ADDR_OSC_STOP_DET, ADDR_FAST_OSC_CTRL,
      ADDR_FAST_OSC_TRIM, ADDR_FAST_OSC_DIV, ADDR_VOLTAGE_DET, ADDR_WRITE_PROTECT,
      ADDR_STATUS: mapped = 1'b1;
      default:     mapped = 1'b0;
    endcase
  end

  // zero wait state slave; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  assign status = {1'b0, clock_ctrl.cpu_div_shift, lost_reg, monitor_active};

  // main clock and slow oscillator are foreign to clk_sys: two flops, third for edges
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      main_sync_reg <= 3'h0;
      slow_sync_reg <= 3'h0;
    end
    else
    begin
      main_sync_reg <= {main_sync_reg[1:0], main_osc_input};
      slow_sync_reg <= {slow_sync_reg[1:0], slow_osc_clk};
    end
  end

  assign main_edge = main_sync_reg[2] != main_sync_reg[1];
  assign slow_edge = slow_sync_reg[1] && !slow_sync_reg[2];

  // loss detector: slow edges with no main edge in between
  always_comb
  begin
    loss_count_next = loss_count_reg;
    lost_next       = lost_reg;
    if (main_edge)
    begin
      loss_count_next = 3'h0;
      lost_next       = 1'b0;
    end
    else if (slow_edge && !lost_reg)
    begin
      if (loss_count_reg == 3'(LOSS_SLOW_EDGES - 1))
        lost_next = 1'b1;
      else
        loss_count_next = loss_count_reg + 3'h1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || soft_reset)
    begin
      loss_count_reg <= 3'h0;
      lost_reg       <= 1'b0;
    end
    else
    begin
      loss_count_reg <= loss_count_next;
      lost_reg       <= lost_next;
    end
  end

  // register file next state
  always_comb
  begin
    clock_mode_next          = clock_mode_reg;
    clock_mode_ext_next      = clock_mode_ext_reg;
    osc_stop_detect_next     = osc_stop_detect_reg;
    fast_osc_ctrl_next       = fast_osc_ctrl_reg;
    fast_osc_trim_next       = fast_osc_trim_reg;
    fast_osc_divider_next    = fast_osc_divider_reg;
    voltage_detect_ctrl_next = voltage_detect_ctrl_reg;
    write_protect_next       = write_protect_reg;
    prdata_next              = prdata;

    if (wr && clock_we)
    begin
      case (paddr)
        ADDR_CLOCK_MODE:
        begin
          clock_mode_next = wd;
          clock_mode_next[SUB_CLOCK_OSCILLATE_BIT] = wd[SUB_CLOCK_OSCILLATE_BIT] ||
            clock_mode_reg[SUB_CLOCK_OSCILLATE_BIT];
        end
        ADDR_CLOCK_MODE_EXT:
        begin
          clock_mode_ext_next = wd;
          clock_mode_ext_next[MAIN_PIN_SELECT_BIT] = wd[MAIN_PIN_SELECT_BIT] ||
            clock_mode_ext_reg[MAIN_PIN_SELECT_BIT];
          if (wdt_protect_mode)
            clock_mode_ext_next[STOP_MODE_BIT_POS] = stop_mode;
        end
        ADDR_OSC_STOP_DET:
        begin
          osc_stop_detect_next[2:0] = wd[2:0];
          if (stopped_flag && !wd[ONCHIP_CLOCK_SELECT_BIT])
            osc_stop_detect_next[ONCHIP_CLOCK_SELECT_BIT] = 1'b1;
        end
        ADDR_FAST_OSC_TRIM: fast_osc_trim_next = wd;
        default: ;
      endcase
    end

    if (wr)
    begin
      case (paddr)
        ADDR_FAST_OSC_CTRL: fast_osc_ctrl_next = {6'h00, wd[1:0]};
        ADDR_FAST_OSC_DIV:  fast_osc_divider_next = {5'h00, wd[2:0]};
        ADDR_WRITE_PROTECT: write_protect_next = wd & 8'h09;
        ADDR_VOLTAGE_DET:
          if (volt_we)
            voltage_detect_ctrl_next = wd & 8'hE0;
        default: ;
      endcase
    end

    // stop entry forces slow cpu divide and high drive on both oscillators
    if (clock_mode_ext_next[STOP_MODE_BIT_POS] && !stop_mode)
    begin
      clock_mode_next[CPU_DIV8_SELECT_BIT]        = 1'b1;
      clock_mode_next[SUB_DRIVE_CAPACITY_BIT]     = 1'b1;
      clock_mode_ext_next[MAIN_DRIVE_CAPACITY_BIT] = 1'b1;
    end
    if (stop_wake)
      clock_mode_ext_next[STOP_MODE_BIT_POS] = 1'b0;

    // hardware set applied last so it wins over a software clear in the same cycle
    if (lost_next && osc_stop_detect_next[1:0] == 2'b11)
      osc_stop_detect_next[ONCHIP_CLOCK_SELECT_BIT] = 1'b1;
    osc_stop_detect_next[MAIN_CLOCK_STOPPED_BIT] = lost_next && osc_stop_detect_next[0];

    // slow stop bit mirrors the on-chip select; a protect mode write cannot move it
    clock_mode_ext_next[SLOW_OSC_STOP_BIT] = !osc_stop_detect_next[ONCHIP_CLOCK_SELECT_BIT];

    if (rd_setup)
    begin
      case (paddr)
        ADDR_CLOCK_MODE:     prdata_next = {24'h0, clock_mode_reg};
        ADDR_CLOCK_MODE_EXT: prdata_next = {24'h0, clock_mode_ext_reg};
        ADDR_OSC_STOP_DET:   prdata_next = {24'h0, osc_stop_detect_reg};
        ADDR_FAST_OSC_CTRL:  prdata_next = {24'h0, fast_osc_ctrl_reg};
        ADDR_FAST_OSC_TRIM:  prdata_next = {24'h0, fast_osc_trim_reg};
        ADDR_FAST_OSC_DIV:   prdata_next = {24'h0, fast_osc_divider_reg};
        ADDR_VOLTAGE_DET:    prdata_next = {24'h0, voltage_detect_ctrl_reg};
        ADDR_WRITE_PROTECT:  prdata_next = {24'h0, write_protect_reg};
        ADDR_STATUS:         prdata_next = {24'h0, status};
        default:             prdata_next = 32'h0000_0000;
      endcase
    end
  end

  // software, watchdog and monitor resets arrive as soft_reset and spare the voltage register
  always_ff @(posedge clk_sys)
  begin
    if (rst || soft_reset)
    begin
      clock_mode_reg       <= CLOCK_MODE_RESET;
      clock_mode_ext_reg   <= CLOCK_MODE_EXT_RESET;
      osc_stop_detect_reg  <= OSC_STOP_DET_RESET;
      fast_osc_ctrl_reg    <= FAST_OSC_CTRL_RESET;
      fast_osc_trim_reg    <= FAST_OSC_TRIM_RESET;
      fast_osc_divider_reg <= FAST_OSC_DIV_RESET;
      write_protect_reg    <= WRITE_PROTECT_RESET;
      prdata               <= 32'h0000_0000;
    end
    else
    begin
      clock_mode_reg       <= clock_mode_next;
      clock_mode_ext_reg   <= clock_mode_ext_next;
      osc_stop_detect_reg  <= osc_stop_detect_next;
      fast_osc_ctrl_reg    <= fast_osc_ctrl_next;
      fast_osc_trim_reg    <= fast_osc_trim_next;
      fast_osc_divider_reg <= fast_osc_divider_next;
      write_protect_reg    <= write_protect_next;
      prdata               <= prdata_next;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      voltage_detect_ctrl_reg <= VOLTAGE_DET_RESET;
    else
      voltage_detect_ctrl_reg <= voltage_detect_ctrl_next;
  end

  genvar m;
  generate
    for (m = 0; m < MONITORS; m++)
    begin : g_monitor
      enable_delay_timer #(
        .COUNT (ENABLE_DELAY_CYCLES)
      ) u_delay (
        .clk_sys (clk_sys),
        .rst     (rst),
        .enable  (voltage_detect_ctrl_reg[MONITOR0_ENABLE_BIT + m]),
        .active  (monitor_active[m])
      );
    end
  endgenerate

  // clock tree controls
  always_comb
  begin
    clock_ctrl = '0;
    clock_ctrl.main_feedback_en = !stop_mode;
    clock_ctrl.sub_feedback_en  = !stop_mode;
    // an external clock keeps arriving; only the oscillation buffer is switched off
    clock_ctrl.main_buffer_en   = !clock_mode_reg[MAIN_CLOCK_STOP_BIT] && !stop_mode;
    clock_ctrl.main_input_en    = clock_mode_ext_reg[MAIN_PIN_SELECT_BIT] && !stop_mode;
    clock_ctrl.port_pins_free   = !clock_mode_reg[SUB_CLOCK_OSCILLATE_BIT] &&
      clock_mode_reg[MAIN_CLOCK_STOP_BIT] && !clock_mode_ext_reg[MAIN_PIN_SELECT_BIT];
    clock_ctrl.fast_prediv_en   = onchip_sel && fast_osc_ctrl_reg[ONCHIP_OSC_SELECT_BIT];
    clock_ctrl.slow_osc_run     = !clock_mode_ext_reg[SLOW_OSC_STOP_BIT] && !stop_mode;
    clock_ctrl.fast_osc_run     = fast_osc_ctrl_reg[FAST_OSC_ON_BIT] && !stop_mode;
    if (clock_mode_reg[CPU_DIV8_SELECT_BIT])
      clock_ctrl.cpu_div_shift = DIV8_SHIFT;
    else
    begin
      case ({clock_mode_ext_reg[CPU_DIVIDER_HIGH_BIT], clock_mode_ext_reg[CPU_DIVIDER_LOW_BIT]})
        2'b00:   clock_ctrl.cpu_div_shift = 3'h0;
        2'b01:   clock_ctrl.cpu_div_shift = 3'h1;
        2'b10:   clock_ctrl.cpu_div_shift = 3'h2;
        default: clock_ctrl.cpu_div_shift = DIV16_SHIFT;
      endcase
    end
  end

  // oscillator output pins: only stop mode drives them digitally
  always_comb
  begin
    osc_pins.sub_o   = 1'b1;
    osc_pins.sub_oe  = stop_mode && clock_mode_reg[SUB_CLOCK_OSCILLATE_BIT];
    osc_pins.main_o  = 1'b1;
    osc_pins.main_oe = stop_mode && clock_mode_ext_reg[MAIN_PIN_SELECT_BIT];
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_clock_reg_protect: assert property (wr && !clock_we && paddr == ADDR_FAST_OSC_TRIM |=>
    $stable(fast_osc_trim_reg)) else $error("trim written without write enable");
  a_sub_osc_sticky: assert property (clock_mode_reg[SUB_CLOCK_OSCILLATE_BIT] && !soft_reset |=>
    clock_mode_reg[SUB_CLOCK_OSCILLATE_BIT]) else $error("sub oscillate bit cleared");
  a_main_pin_sticky: assert property (clock_mode_ext_reg[MAIN_PIN_SELECT_BIT] && !soft_reset |=>
    clock_mode_ext_reg[MAIN_PIN_SELECT_BIT]) else $error("main pin select cleared");
  a_stop_entry_bits: assert property ($rose(stop_mode) |-> clock_mode_reg[CPU_DIV8_SELECT_BIT] &&
    clock_mode_reg[SUB_DRIVE_CAPACITY_BIT] && clock_mode_ext_reg[MAIN_DRIVE_CAPACITY_BIT])
    else $error("stop entry did not set divide and drive bits");
  a_feedback_stop: assert property (stop_mode |-> !clock_ctrl.main_feedback_en)
    else $error("feedback resistor connected in stop mode");
  a_pins_stop_drive: assert property (stop_mode && clock_mode_ext_reg[MAIN_PIN_SELECT_BIT] |->
    osc_pins.main_oe && osc_pins.main_o) else $error("main output not high in stop mode");
  a_slow_stop_mirror: assert property (clock_mode_ext_reg[SLOW_OSC_STOP_BIT] != onchip_sel)
    else $error("slow stop bit does not follow on-chip select");
  a_div8_override: assert property (clock_mode_reg[CPU_DIV8_SELECT_BIT] |->
    clock_ctrl.cpu_div_shift == DIV8_SHIFT) else $error("div8 select not honoured");
  a_loss_switch: assert property ($rose(lost_reg) && osc_stop_detect_reg[1:0] == 2'b11 && !soft_reset |=>
    onchip_sel [*2]) else $error("loss did not force on-chip clock");
  a_flag_zero: assert property (osc_stop_detect_reg[1:0] == 2'b00 |->
    !osc_stop_detect_reg[MAIN_CLOCK_STOPPED_BIT]) else $error("stopped flag set with detection off");
  a_monitor_wait: assert property ($rose(voltage_detect_ctrl_reg[MONITOR0_ENABLE_BIT]) |->
    !monitor_active[0] ##1 !monitor_active[0]) else $error("monitor active without delay");

  c_stop_entry: cover property ($rose(stop_mode));
  c_loss_switch: cover property ($rose(lost_reg) && osc_stop_detect_reg[1:0] == 2'b11);
  c_monitor_up: cover property ($rose(monitor_active[0]));
  c_unmapped: cover property (pslverr);

endmodule

/* testbench/clock_source_control_regs_tb.sv */
// self-checking bench for the clock source control registers over apb
`timescale 1ns/10ps
module clock_source_control_regs_tb;
  import clock_ctrl_pkg::*;
  localparam int DLY = 10;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        soft_reset = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wdt_protect_mode = 1'b0;
  logic        stop_wake = 1'b0;
  logic        main_osc_input = 1'b0;
  logic        slow_osc_clk = 1'b0;
  logic        main_run = 1'b1;
  logic [2:0]  slow_cnt = 3'h0;
  logic        last_err;
  logic [31:0] q;
  clock_ctrl_t clock_ctrl;
  osc_pins_t   osc_pins;
  logic [2:0]  monitor_active;
  int          fails = 0;
  int          tests_run = 0;
  int          n;
  logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
  logic [7:0]  rv [8] = '{8'h68, 8'h20, 8'h04, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
  logic [2:0]  sh [4] = '{3'h0, 3'h1, 3'h2, 3'h4};

  always #10 clk_sys = ~clk_sys;

  // main clock toggles every cycle while alive; slow clock is a divided stand-in
  always @(posedge clk_sys)
  begin
    if (main_run)
      main_osc_input <= ~main_osc_input;
    slow_cnt     <= slow_cnt + 3'h1;
    slow_osc_clk <= slow_cnt[2];
  end

  clock_source_control_regs #(.ENABLE_DELAY_CYCLES(DLY)) i_dut (
    .clk_sys          (clk_sys),
    .rst              (rst),
    .soft_reset       (soft_reset),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .wdt_protect_mode (wdt_protect_mode),
    .stop_wake        (stop_wake),
    .main_osc_input   (main_osc_input),
    .slow_osc_clk     (slow_osc_clk),
    .clock_ctrl       (clock_ctrl),
    .osc_pins         (osc_pins),
    .monitor_active   (monitor_active)
  );

  task summarize;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
      fails++;
    end
  endtask

  // one apb transfer; request held until pready is sampled high, no fixed latency assumed
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      fails++;
      summarize();
    end
    r        = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, a, {24'h0, d}, r);
  endtask

  task rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    check(what, r, {24'h0, exp});
  endtask

  // one-cycle strobe: 0 leaves stop mode, 1 soft reset, 2 full reset; by selector, as a copied argument never reaches the port
  task pulse(input int sel);
    @(posedge clk_sys);
    if (sel == 0)
      stop_wake <= 1'b1;
    else if (sel == 1)
      soft_reset <= 1'b1;
    else
      rst <= 1'b1;
    @(posedge clk_sys);
    stop_wake  <= 1'b0;
    soft_reset <= 1'b0;
    rst        <= 1'b0;
  endtask

  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++)
      rd_chk("reset value", ra[i], rv[i]);
    check("reset shift", 32'(clock_ctrl.cpu_div_shift), 32'(DIV8_SHIFT));
    $display("test reset done");
    wr(8'h00, 8'h00);
    rd_chk("protected mode", 8'h00, 8'h68);
    wr(8'h10, 8'h55);
    rd_chk("protected trim", 8'h10, 8'h80);
    wr(8'h1C, 8'h01);
    wr(8'h10, 8'h55);
    rd_chk("open trim", 8'h10, 8'h55);
    $display("test protect done");
    wr(8'h00, 8'h28);
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h04, 8'(k << 6) | 8'h20);
      rd_chk("divider bits", 8'h04, 8'(k << 6) | 8'h20);
      check("cpu shift", 32'(clock_ctrl.cpu_div_shift), 32'(sh[k]));
    end
    check("pins free", 32'(clock_ctrl.port_pins_free), 32'h1);
    wr(8'h04, 8'h38);
    rd_chk("pin select and slow stop", 8'h04, 8'h28);
    wr(8'h04, 8'h20);
    rd_chk("pin select sticky", 8'h04, 8'h28);
    check("pins taken", 32'(clock_ctrl.port_pins_free), 32'h0);
    wr(8'h00, 8'h38);
    wr(8'h00, 8'h28);
    rd_chk("sub osc sticky", 8'h00, 8'h38);
    $display("test sticky bits done");
    wdt_protect_mode <= 1'b1;
    wr(8'h04, 8'h29);
    rd_chk("stop under protect", 8'h04, 8'h28);
    wdt_protect_mode <= 1'b0;
    wr(8'h00, 8'h30);
    wr(8'h04, 8'h08);
    wr(8'h04, 8'h09);
    rd_chk("stop entry mode", 8'h00, 8'h78);
    rd_chk("stop entry ext", 8'h04, 8'h29);
    check("feedback off", 32'(clock_ctrl.main_feedback_en), 32'h0);
    check("stop pins", 32'(osc_pins), 32'hF);
    check("stop shift", 32'(clock_ctrl.cpu_div_shift), 32'(DIV8_SHIFT));
    check("stop tree", 32'(clock_ctrl), 32'h003);
    pulse(0);
    wr(8'h08, 8'h00);
    rd_chk("slow stop mirror", 8'h04, 8'h38);
    check("awake tree", 32'(clock_ctrl), 32'h583);
    check("pins after wake", 32'({osc_pins.main_oe, osc_pins.sub_oe}), 32'h0);
    $display("test stop mode done");
    // detection armed only after selecting the main clock, as software must
    wr(8'h08, 8'h03);
    rd_chk("detect armed", 8'h08, 8'h03);
    main_run <= 1'b0;
    q = 32'h0;
    for (n = 0; n < 40 && q[3] !== 1'b1; n++)
      apb(1'b0, 8'h08, 32'h0, q);
    if (n >= 40)
    begin
      fails++;
      summarize();
    end
    check("loss fallback", q, 32'h0F);
    wr(8'h08, 8'h03);
    rd_chk("select held", 8'h08, 8'h0F);
    wr(8'h08, 8'h04);
    rd_chk("flag off", 8'h08, 8'h04);
    main_run <= 1'b1;
    $display("test loss detect done");
    // legal divider and running fast oscillator before the select moves
    wr(8'h14, 8'h02);
    rd_chk("fast div", 8'h14, 8'h02);
    wr(8'h0C, 8'h01);
    wr(8'h0C, 8'h03);
    rd_chk("fast ctrl", 8'h0C, 8'h03);
    check("fast predivide", 32'(clock_ctrl.fast_prediv_en), 32'h1);
    check("fast tree", 32'(clock_ctrl), 32'h5BB);
    wr(8'h0C, 8'h01);
    rd_chk("fast ctrl slow", 8'h0C, 8'h01);
    check("slow selected", 32'(clock_ctrl.fast_prediv_en), 32'h0);
    wr(8'h0C, 8'h00);
    $display("test fast osc done");
    wr(8'h1C, 8'h09);
    wr(8'h18, 8'h20);
    check("monitor waits", 32'(monitor_active), 32'h0);
    repeat (DLY + 2) @(posedge clk_sys);
    check("monitor live", 32'(monitor_active), 32'h1);
    pulse(1);
    rd_chk("voltage kept", 8'h18, 8'h20);
    rd_chk("mode reset", 8'h00, 8'h68);
    check("monitor kept", 32'(monitor_active), 32'h1);
    rd_chk("status", 8'h20, 8'h31);
    wr(8'h1C, 8'h01);
    wr(8'h04, 8'h21);
    rd_chk("stop set", 8'h04, 8'h21);
    check("stop pins input", 32'(osc_pins), 32'hA);
    pulse(0);
    $display("test voltage done");
    wr(8'h30, 8'hFF);
    rd_chk("unmapped", 8'h30, 8'h00);
    check("unmapped error", 32'(last_err), 32'h1);
    pulse(2);
    rd_chk("voltage cleared", 8'h18, 8'h00);
    $display("test unmapped and reset done");
    summarize();
  end
endmodule
